// ### pkg/aof_regs.svh
// register offsets, field positions, reset values and widths of the output frame formatter
`ifndef AOF_REGS_SVH
`define AOF_REGS_SVH

`define AOF_OFS_FMT_CTL      8'h10
`define AOF_OFS_SPAN_REF     8'h14
`define AOF_OFS_SAMPLE       8'h18
`define AOF_OFS_FLAGS        8'h1C
`define AOF_OFS_IRQ_STATUS   8'h20
`define AOF_OFS_IRQ_MASK     8'h24

`define AOF_FMT_WMASK        32'h0000_7D0F
`define AOF_SPAN_WMASK       32'h0000_004F
`define AOF_FMT_RESET        32'h0000_0000
`define AOF_SPAN_RESET       32'h0000_0000

`define AOF_BIT_TAG          14
`define AOF_BIT_SUP_HI       12
`define AOF_BIT_SUP_LO       13
`define AOF_BIT_IN_HI        10
`define AOF_BIT_IN_LO        11
`define AOF_BIT_SPAN         8
`define AOF_BIT_PAR          3
`define AOF_BIT_SRC_MSB      2
`define AOF_BIT_VREF_OFF     6

`define AOF_SAMPLE_W         12
`define AOF_FRAME_W          28
`define AOF_CNT_W            5

`define AOF_IRQ_FRAME_DONE   0
`define AOF_IRQ_FRAME_ABORT  1

`endif

// ### pkg/aof_pkg.sv
// types shared by the output frame formatter
package aof_pkg;

  typedef struct packed {
    logic       tag_en;
    logic [1:0] sup_sel;
    logic [1:0] in_sel;
    logic       span_en;
    logic       parity_append_enable;
    logic [2:0] src;
  } aof_fmt_type;

  typedef struct packed {
    logic [3:0] chip_tag;
    logic       sup_hi;
    logic       sup_lo;
    logic       in_hi;
    logic       in_lo;
    logic [3:0] span;
  } aof_side_type;

  typedef enum logic [1:0] {
    AOF_IDLE  = 2'b00,
    AOF_SHIFT = 2'b01
  } aof_state_type;

endpackage : aof_pkg

// ### verilog/aof_frame_build.sv
// combinational assembly of one output frame from data source, side fields and parity
`timescale 1ns/1ps
`default_nettype none
`include "aof_regs.svh"

module aof_frame_build (
  input  wire aof_pkg::aof_fmt_type       fmt,
  input  wire aof_pkg::aof_side_type      side,
  input  wire logic [`AOF_SAMPLE_W-1:0]   sample,
  output logic [`AOF_FRAME_W-1:0]         frame,
  output logic [`AOF_CNT_W-1:0]           frame_len
);

  logic [`AOF_SAMPLE_W-1:0] value;
  logic                     value_par;
  logic                     frame_par;

  // source selection: test patterns replace the conversion result
  always_comb begin
    case (fmt.src)
      3'h4:    value = 12'h000;
      3'h5:    value = 12'hFFF;
      3'h6:    value = 12'hAAA;
      3'h7:    value = 12'hCCC;
      default: value = sample;
    endcase
  end

  // frame is MSB aligned; fields appended in order after the value
  always_comb begin
    logic [`AOF_FRAME_W-1:0] acc;
    logic [`AOF_CNT_W-1:0]   n;
    acc = '0;
    n   = 5'(`AOF_SAMPLE_W);
    acc[`AOF_FRAME_W-1 -: `AOF_SAMPLE_W] = value;
    frame_par = ^value;
    value_par = ^value;
    if (fmt.tag_en) begin
      acc[`AOF_FRAME_W-1-n -: 4] = side.chip_tag;
      frame_par = frame_par ^ (^side.chip_tag);
      n = n + 5'h4;
    end
    if (fmt.sup_sel[0]) begin
      acc[`AOF_FRAME_W-1-n] = side.sup_hi;
      frame_par = frame_par ^ side.sup_hi;
      n = n + 5'h1;
    end
    if (fmt.sup_sel[1]) begin
      acc[`AOF_FRAME_W-1-n] = side.sup_lo;
      frame_par = frame_par ^ side.sup_lo;
      n = n + 5'h1;
    end
    if (fmt.in_sel[0]) begin
      acc[`AOF_FRAME_W-1-n] = side.in_hi;
      frame_par = frame_par ^ side.in_hi;
      n = n + 5'h1;
    end
    if (fmt.in_sel[1]) begin
      acc[`AOF_FRAME_W-1-n] = side.in_lo;
      frame_par = frame_par ^ side.in_lo;
      n = n + 5'h1;
    end
    if (fmt.span_en) begin
      acc[`AOF_FRAME_W-1-n -: 4] = side.span;
      frame_par = frame_par ^ (^side.span);
      n = n + 5'h4;
    end
    if (fmt.parity_append_enable) begin
      acc[`AOF_FRAME_W-1-n] = value_par;
      acc[`AOF_FRAME_W-2-n] = frame_par;
      n = n + 5'h2;
    end
    frame     = acc;
    frame_len = n;
  end

endmodule : aof_frame_build
`default_nettype wire

// ### verilog/aof_top.sv
// output frame formatter: AXI4-Lite registers, frame assembly and serial shift-out
//
// Operation
// - format register bits 31-16 read zero
// - bit 14 appends 4-bit chip tag
// - bits 13-12 pick supply alert flags
// - bits 11-10 pick input alert flags
// - bits 15, 9, 7-4 reserved, read zero
// - bit 8 appends 4-bit span code
// - bit 3 appends two parity bits
// - first parity: even over result only
// - second parity: even over result and appended fields
// - frame parity excludes result parity bit
// - source field picks data or pattern
// - span/reference register at 14h
// - format register at byte 10h
// - bit 6 turns on-chip reference off
// - span code bits 3-0, reset 0000b
`timescale 1ns/1ps
`default_nettype none
`include "aof_regs.svh"

module aof_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // serial link to the host
  input  wire logic        link_sclk,
  input  wire logic        link_cs_n,
  output logic             serial_out_lines,
  // device side
  input  wire logic [3:0]  chip_tag,
  output logic             onchip_vref_off,
  output logic [3:0]       span_code,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [31:0] fmt_q;
  logic [31:0] span_q;
  logic [31:0] sample_q;
  logic [3:0]  flags_q;
  logic [1:0]  irq_stat_q;
  logic [1:0]  irq_mask_q;
  logic        aw_held_q;
  logic        w_held_q;
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb, input logic [31:0] wmask);
    logic [31:0] m;
    m = 32'h0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    merge = ((old & ~m) | (nw & m)) & wmask;
  endfunction : merge

  // register decode ignores the byte-lane bits of the address
  function automatic logic [7:0] word_ofs(input logic [7:0] a);
    word_ofs = a & 8'hFC;
  endfunction : word_ofs

  aof_pkg::aof_fmt_type  fmt;
  aof_pkg::aof_side_type side;
  assign fmt = '{tag_en: fmt_q[`AOF_BIT_TAG], sup_sel: fmt_q[`AOF_BIT_SUP_LO:`AOF_BIT_SUP_HI],
                 in_sel: fmt_q[`AOF_BIT_IN_LO:`AOF_BIT_IN_HI], span_en: fmt_q[`AOF_BIT_SPAN],
                 parity_append_enable: fmt_q[`AOF_BIT_PAR], src: fmt_q[`AOF_BIT_SRC_MSB:0]};
  // chip tag is a static strap on this clock, so it skips the synchroniser
  assign side = '{chip_tag: chip_tag, sup_hi: flags_q[0], sup_lo: flags_q[1],
                  in_hi: flags_q[2], in_lo: flags_q[3], span: span_q[3:0]};

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path: address and data taken in either order
  // one write in flight: a new address or data beat is held until the
  // previous response has been accepted, so back-to-back writes stall here
  logic do_write;
  assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q     <= 1'b0;
      w_held_q      <= 1'b0;
      aw_addr_q     <= 8'h00;
      w_data_q      <= 32'h0000_0000;
      w_strb_q      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
    end else begin
      s_axi_awready <= !aw_held_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_held_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held_q    <= 1'b0;
        w_held_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (word_ofs(aw_addr_q))
          `AOF_OFS_FMT_CTL, `AOF_OFS_SPAN_REF, `AOF_OFS_SAMPLE,
          `AOF_OFS_FLAGS, `AOF_OFS_IRQ_STATUS, `AOF_OFS_IRQ_MASK: s_axi_bresp <= 2'h0;
          default: s_axi_bresp <= 2'h2;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fmt_q      <= `AOF_FMT_RESET;
      span_q     <= `AOF_SPAN_RESET;
      sample_q   <= 32'h0000_0000;
      flags_q    <= 4'h0;
      irq_mask_q <= 2'h0;
    end else if (do_write) begin
      // sample and alert flags stand in for the converter core; software loads them
      case (word_ofs(aw_addr_q))
        // write mask keeps reserved bits zero
        `AOF_OFS_FMT_CTL:  fmt_q  <= merge(fmt_q, w_data_q, w_strb_q, `AOF_FMT_WMASK);
        `AOF_OFS_SPAN_REF: span_q <= merge(span_q, w_data_q, w_strb_q, `AOF_SPAN_WMASK);
        `AOF_OFS_SAMPLE:   sample_q <= merge(sample_q, w_data_q, w_strb_q, 32'h0000_0FFF);
        `AOF_OFS_FLAGS:    flags_q  <= w_strb_q[0] ? w_data_q[3:0] : flags_q;
        `AOF_OFS_IRQ_MASK: irq_mask_q <= w_strb_q[0] ? w_data_q[1:0] : irq_mask_q;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path; unmapped reads answer SLVERR with zero data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'h0;
        case (word_ofs(s_axi_araddr))
          `AOF_OFS_FMT_CTL:    s_axi_rdata <= fmt_q;
          `AOF_OFS_SPAN_REF:   s_axi_rdata <= span_q;
          `AOF_OFS_SAMPLE:     s_axi_rdata <= sample_q;
          `AOF_OFS_FLAGS:      s_axi_rdata <= {28'h0, flags_q};
          `AOF_OFS_IRQ_STATUS: s_axi_rdata <= {30'h0, irq_stat_q};
          `AOF_OFS_IRQ_MASK:   s_axi_rdata <= {30'h0, irq_mask_q};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reference and span outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      onchip_vref_off <= 1'b0;
      span_code       <= 4'h0;
    end else begin
      onchip_vref_off <= span_q[`AOF_BIT_VREF_OFF];
      span_code       <= span_q[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link inputs pass two flops before use
  // limitation: each sclk phase must last at least two aclk cycles, or an
  // edge is lost in the synchroniser and the frame slips by one bit
  logic [1:0] sclk_sync_q;
  logic [1:0] cs_sync_q;
  logic       sclk_prev_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sclk_sync_q <= 2'b00;
      cs_sync_q   <= 2'b11;
      sclk_prev_q <= 1'b0;
    end else begin
      sclk_sync_q <= {sclk_sync_q[0], link_sclk};
      cs_sync_q   <= {cs_sync_q[0], link_cs_n};
      sclk_prev_q <= sclk_sync_q[1];
    end
  end

  logic sclk_fall;
  assign sclk_fall = sclk_prev_q && !sclk_sync_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // frame shift-out, mode 0: data changes on falling sclk
  // clocks beyond the last bit are ignored and the line keeps the last bit
  logic [`AOF_FRAME_W-1:0] frame;
  logic [`AOF_CNT_W-1:0]   frame_len;
  logic [`AOF_FRAME_W-1:0] shift_q;
  logic [`AOF_CNT_W-1:0]   left_q;
  aof_pkg::aof_state_type  state_q;
  logic                    ev_done;
  logic                    ev_abort;

  aof_frame_build u_build (
    .fmt       (fmt),
    .side      (side),
    .sample    (sample_q[`AOF_SAMPLE_W-1:0]),
    .frame     (frame),
    .frame_len (frame_len)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q          <= aof_pkg::AOF_IDLE;
      shift_q          <= '0;
      left_q           <= 5'h00;
      serial_out_lines <= 1'b0;
      ev_done          <= 1'b0;
      ev_abort         <= 1'b0;
    end else begin
      ev_done  <= 1'b0;
      ev_abort <= 1'b0;
      case (state_q)
        aof_pkg::AOF_IDLE: begin
          if (!cs_sync_q[1]) begin
            // frame latched at select so settings changes never tear a frame
            shift_q          <= {frame[`AOF_FRAME_W-2:0], 1'b0};
            serial_out_lines <= frame[`AOF_FRAME_W-1];
            left_q           <= frame_len - 5'h1;
            state_q          <= aof_pkg::AOF_SHIFT;
          end
        end
        aof_pkg::AOF_SHIFT: begin
          if (cs_sync_q[1]) begin
            // short read by the host loses the tail of the frame
            ev_done          <= (left_q == 5'h00);
            ev_abort         <= (left_q != 5'h00);
            serial_out_lines <= 1'b0;
            state_q          <= aof_pkg::AOF_IDLE;
          end else if (sclk_fall && left_q != 5'h00) begin
            serial_out_lines <= shift_q[`AOF_FRAME_W-1];
            shift_q          <= {shift_q[`AOF_FRAME_W-2:0], 1'b0};
            left_q           <= left_q - 5'h1;
          end
        end
        default: state_q <= aof_pkg::AOF_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts: sticky, write one to clear, set wins
  logic [1:0] clr;
  // irq follows the status one cycle late, as it is a registered output
  assign clr = (do_write && word_ofs(aw_addr_q) == `AOF_OFS_IRQ_STATUS && w_strb_q[0])
               ? w_data_q[1:0] : 2'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_q <= 2'h0;
      irq        <= 1'b0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~clr) | {ev_abort, ev_done};
      irq        <= |(irq_stat_q & irq_mask_q);
    end
  end

endmodule : aof_top
`default_nettype wire

// ### bench/aof_top_props.sv
// concurrent checks on the ports of the output frame formatter
`timescale 1ns/1ps
`default_nettype none
`include "aof_regs.svh"

module aof_top_props (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        link_cs_n,
  input wire logic        serial_out_lines,
  input wire logic        onchip_vref_off,
  input wire logic [3:0]  span_code
);
  default clocking ck @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [7:0] ra_q;
  logic       mapped;
  ////////////////////////////////////////////////////////////////////////////////
  // read address is gone from the bus by the time the answer comes, so keep it
  always_ff @(posedge aclk) begin
    if (!aresetn) ra_q <= 8'h00;
    else if (s_axi_arvalid && s_axi_arready) ra_q <= s_axi_araddr;
  end
  assign mapped = ra_q >= 8'h10 && ra_q <= 8'h24 && ra_q[1:0] == 2'b00;
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_aw_wait; s_axi_awvalid && !s_axi_awready; endsequence
  sequence s_cs_idle; link_cs_n [*8]; endsequence
  sequence s_rd_fmt; s_axi_rvalid && ra_q == `AOF_OFS_FMT_CTL; endsequence
  sequence s_rd_span; s_axi_rvalid && ra_q == `AOF_OFS_SPAN_REF; endsequence
  a_aw_taken: assert property (s_aw_wait |-> ##[1:3] s_axi_awready)
    else $error("write address not taken");
  a_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  a_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped or changed");
  a_r_follows: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_r_resp: assert property (s_axi_rvalid |-> s_axi_rresp == (mapped ? 2'b00 : 2'b10))
    else $error("read response code wrong");
  a_fmt_zero: assert property (s_rd_fmt |-> (s_axi_rdata & ~`AOF_FMT_WMASK) == 32'h0)
    else $error("format register reserved bits set");
  a_span_zero: assert property (s_rd_span |-> (s_axi_rdata & ~`AOF_SPAN_WMASK) == 32'h0)
    else $error("span register reserved bits set");
  a_span_copy: assert property (s_rd_span |-> s_axi_rdata[3:0] == span_code
    && s_axi_rdata[6] == onchip_vref_off) else $error("span outputs differ from register");
  a_out_cause: assert property ($changed(span_code) || $changed(onchip_vref_off) |->
    $past(s_axi_wvalid) || $past(s_axi_wvalid, 2) || $past(s_axi_wvalid, 3)
    || $past(s_axi_wvalid, 4)) else $error("span outputs moved without a write");
  a_idle_low: assert property (s_cs_idle |-> !serial_out_lines)
    else $error("serial line not low between frames");
endmodule : aof_top_props

bind aof_top aof_top_props i_props (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .link_cs_n(link_cs_n),
  .serial_out_lines(serial_out_lines), .onchip_vref_off(onchip_vref_off),
  .span_code(span_code));
`default_nettype wire

// ### bench/aof_host_model.sv
// serial host that clocks frames out of the formatter
`timescale 1ns/1ps
`default_nettype none

module aof_host_model (
  input  wire logic serial_out_lines,
  output logic      link_sclk,
  output logic      link_cs_n
);
  initial begin
    link_sclk = 1'b0;
    link_cs_n = 1'b1;
  end
  // long low phase: the device shifts on the fall with a few cycles of sync lag
  task automatic read_frame(input int n, output logic [27:0] got);
    got = 28'h0;
    #7 link_cs_n = 1'b0;
    #160;
    for (int i = 0; i < n; i++) begin
      link_sclk = 1'b1;
      got = {got[26:0], serial_out_lines};
      #40 link_sclk = 1'b0;
      #120;
    end
    link_cs_n = 1'b1;
    #200;
  endtask : read_frame
endmodule : aof_host_model
`default_nettype wire

// ### bench/aof_top_tb.sv
// self-checking bench of the output frame formatter
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin bad_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end

module aof_top_tb;
  logic        aclk = 1'b0;
  logic        aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready;
  logic        bvalid, arready, rvalid, sclk, csn, sdo, vref, irq;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic [3:0]  tag, span;
  logic [3:0]  wstrb;
  logic [3:0]  strb = 4'hF;
  logic [31:0] rs = 32'h7;
  logic [3:0]  sp_tab [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'h9, 4'hA, 4'hB};
  int          bad_count, comparisons;
  always #10 aclk = ~aclk;
  aof_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .link_sclk(sclk),
    .link_cs_n(csn), .serial_out_lines(sdo), .chip_tag(tag), .onchip_vref_off(vref),
    .span_code(span), .irq(irq));
  aof_host_model i_host (.serial_out_lines(sdo), .link_sclk(sclk), .link_cs_n(csn));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic results();
    if (bad_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results
  task automatic guard(inout int i);
    i++;
    if (i > 300) begin
      bad_count++;
      results();
    end
  endtask : guard
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : rnd
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int i;
    logic g;
    i = 0;
    g = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= strb;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!g) begin
      @(posedge aclk);
      guard(i);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        g = 1'b1;
      end
    end
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int i;
    logic g;
    i = 0;
    g = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!g) begin
      @(posedge aclk);
      guard(i);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        g = 1'b1;
      end
    end
  endtask : rd
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
    `CHK(r, 2'b00)
  endtask : wreg
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    `CHK(r, 2'b00)
    `CHK(d, e)
  endtask : rchk
  // returns the bit count above the frame, bits right-aligned, first bit highest
  function automatic logic [33:0] exp_frame(input logic [31:0] f, input logic [11:0] s,
      input logic [3:0] fl, input logic [3:0] tg, input logic [3:0] sp);
    logic [27:0] v;
    logic [5:0]  n;
    logic [11:0] d;
    logic [11:0] cb, en;
    logic        fp;
    case (f[2:0])
      3'h4: d = 12'h000;
      3'h5: d = 12'hFFF;
      3'h6: d = 12'hAAA;
      3'h7: d = 12'hCCC;
      default: d = s;
    endcase
    cb = {tg, fl[0], fl[1], fl[2], fl[3], sp};
    en = {{4{f[14]}}, f[12], f[13], f[10], f[11], {4{f[8]}}};
    v = {16'h0, d};
    n = 6'd12;
    fp = ^d;
    for (int i = 11; i >= 0; i--) if (en[i]) begin
      v = {v[26:0], cb[i]};
      n++;
      fp ^= cb[i];
    end
    if (f[3]) begin
      v = {v[25:0], ^d, fp};
      n += 6'd2;
    end
    return {n, v};
  endfunction : exp_frame
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [33:0] e;
    logic [27:0] got;
    logic [31:0] f, s, d;
    logic [3:0]  sp;
    logic [1:0]  r;
    {aresetn, awvalid, wvalid, bready, arvalid, rready} <= 6'h0;
    {awaddr, araddr, wdata, tag} <= 52'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(8'h10, 32'h0);
    rchk(8'h14, 32'h0);
    `CHK(span, 4'h0)
    wreg(8'h10, 32'hFFFFFFFF);
    rchk(8'h10, 32'h00007D0F);
    strb = 4'h1;
    wreg(8'h10, 32'h0);
    strb = 4'hF;
    rchk(8'h10, 32'h00007D00);
    wreg(8'h14, 32'hFFFFFFFF);
    rchk(8'h14, 32'h0000004F);
    `CHK(vref, 1'b1)
    wreg(8'h14, 32'h0);
    @(posedge aclk);
    `CHK(vref, 1'b0)
    rd(8'h40, d, r);
    `CHK(r, 2'b10)
    `CHK(d, 32'h0)
    wr(8'h44, 32'h1, r);
    `CHK(r, 2'b10)
    wreg(8'h24, 32'h3);
    for (int k = 0; k < 16; k++) begin
      f = (rnd() & 32'h4108) | (k[3:0] << 10) | k[2:0];
      if (k == 0) f = 32'h0;
      if (k == 15) f = 32'h7D0F;
      s = rnd();
      sp = sp_tab[rnd() % 9];
      tag <= s[19:16];
      wreg(8'h10, f);
      wreg(8'h18, {20'h0, s[11:0]});
      wreg(8'h1C, {28'h0, s[23:20]});
      wreg(8'h14, {25'h0, s[24], 2'b00, sp});
      @(posedge aclk);
      `CHK(span, sp)
      e = exp_frame(f, s[11:0], s[23:20], s[19:16], sp);
      i_host.read_frame(int'(e[33:28]), got);
      `CHK(got, e[27:0])
    end
    `CHK(irq, 1'b1)
    rchk(8'h20, 32'h1);
    wreg(8'h20, 32'h1);
    rchk(8'h20, 32'h0);
    `CHK(irq, 1'b0)
    i_host.read_frame(5, got);
    rchk(8'h20, 32'h2);
    `CHK(irq, 1'b1)
    wreg(8'h24, 32'h0);
    rchk(8'h24, 32'h0);
    `CHK(irq, 1'b0)
    results();
  end
endmodule : aof_top_tb
`default_nettype wire
